// ===== dptr_ram.sv
// Dual-port transfer RAM: CPU port and DMA port on one clock
// Functional notes
// RL1: 2 Kbyte dual-ported RAM at the top of Y data space.
// RL2: CPU and DMA ports reach any location in the same cycle independently.
// RL3: DMA accesses never take CPU cycles; CPU timing unaffected by DMA.
// RL4: Same-location writes in one cycle keep the CPU value.
// RL5: No stall or wait toward the CPU, ever, even on collisions.
// RL6: DMA controller stages both outgoing and incoming peripheral data here.
// RL7: 16-bit words of two byte lanes; byte write updates only its lane.
// RL8: On collision the DMA lane write is dropped silently.
`timescale 1ns/1ps
`include "dptr_defs.svh"
module dptr_ram import dptr_pkg::*; (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        cpu_en_in,
	input  wire logic        cpu_wr_in,
	input  wire logic        cpu_byte_in,
	input  wire dptr_baddr_t cpu_addr_in,
	input  wire dptr_word_t  cpu_wdata_in,
	output dptr_word_t       cpu_rdata_out,
	output logic             cpu_stall_out,
	output logic             cpu_addr_err_out,
	input  wire logic        dma_en_in,
	input  wire logic        dma_wr_in,
	input  wire logic        dma_byte_in,
	input  wire dptr_baddr_t dma_addr_in,
	input  wire dptr_word_t  dma_wdata_in,
	output dptr_word_t       dma_rdata_out,
	output logic             dma_addr_err_out
);
	// Storage: 1024 words split in two byte lanes sharing one word decode [RL1]
	logic [`DPTR_LANE_W-1:0] mem_lo [0:`DPTR_DEPTH-1];
	logic [`DPTR_LANE_W-1:0] mem_hi [0:`DPTR_DEPTH-1];

	// Per-port decode results
	dptr_waddr_t cpu_waddr;
	dptr_waddr_t dma_waddr;
	dptr_lanes_t cpu_we;
	dptr_lanes_t dma_we;
	dptr_lanes_t dma_we_eff;
	dptr_word_t  cpu_wd;
	dptr_word_t  dma_wd;
	logic        cpu_al;
	logic        dma_al;

	// Read data and error state
	dptr_word_t  next_cpu_rdata;
	dptr_word_t  next_dma_rdata;
	dptr_word_t  cpu_rdata;
	dptr_word_t  dma_rdata;
	logic        next_cpu_err;
	logic        next_dma_err;
	logic        cpu_err;
	logic        dma_err;

	// Byte reads return the addressed lane in the low byte, upper byte zero [RL7]
	function automatic dptr_word_t lane_pick(input dptr_word_t word, input logic is_byte, input logic odd);
		dptr_word_t res;
		res = word;
		if (is_byte) begin
			res = {8'h00, (odd ? word[15:8] : word[7:0])};
		end
		return res;
	endfunction : lane_pick

	dptr_lane_dec u_cpu_dec (
		.wr_in       (cpu_en_in & cpu_wr_in),
		.byte_in     (cpu_byte_in),
		.addr_in     (cpu_addr_in),
		.wdata_in    (cpu_wdata_in),
		.aligned_out (cpu_al),
		.waddr_out   (cpu_waddr),
		.we_out      (cpu_we),
		.wdata_out   (cpu_wd)
	);

	dptr_lane_dec u_dma_dec (
		.wr_in       (dma_en_in & dma_wr_in),
		.byte_in     (dma_byte_in),
		.addr_in     (dma_addr_in),
		.wdata_in    (dma_wdata_in),
		.aligned_out (dma_al),
		.waddr_out   (dma_waddr),
		.we_out      (dma_we),
		.wdata_out   (dma_wd)
	);

	// Collision: DMA loses only the lanes the CPU also writes this cycle, no error raised
	always_comb begin
		dma_we_eff = dma_we;
		if (cpu_waddr == dma_waddr) begin
			dma_we_eff = dma_we & ~cpu_we; // [RL4] [RL8]
		end
	end

	// Both ports write each cycle in parallel; CPU written last so it wins any overlap [RL2] [RL4]
	always_ff @(posedge clk_sys_in) begin
		if (dma_we_eff[0]) mem_lo[dma_waddr] <= dma_wd[7:0];
		if (dma_we_eff[1]) mem_hi[dma_waddr] <= dma_wd[15:8];
		if (cpu_we[0]) mem_lo[cpu_waddr] <= cpu_wd[7:0];
		if (cpu_we[1]) mem_hi[cpu_waddr] <= cpu_wd[15:8];
	end

	// Read ports: lane pick sits ahead of the output flop so read data leaves a register [RL2] [RL7]
	always_comb begin
		next_cpu_rdata = lane_pick({mem_hi[cpu_waddr], mem_lo[cpu_waddr]}, cpu_byte_in, cpu_addr_in[0]);
		next_dma_rdata = lane_pick({mem_hi[dma_waddr], mem_lo[dma_waddr]}, dma_byte_in, dma_addr_in[0]);
	end

	// One cycle latency, old data on read-during-write, no arbitration between ports
	// Read data is not reset: the array behind it holds no defined value either
	always_ff @(posedge clk_sys_in) begin
		cpu_rdata <= next_cpu_rdata;
		dma_rdata <= next_dma_rdata;
	end

	// Misaligned word access: flagged for one cycle, the write is dropped by the decoder [RL7]
	// The flag is a pulse per access, so a caller that ignores it sees no lasting state
	always_comb begin
		next_cpu_err = cpu_en_in & ~cpu_al;
		next_dma_err = dma_en_in & ~dma_al;
	end

	// Error flags are control state, so they reset
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cpu_err <= 1'b0;
			dma_err <= 1'b0;
		end else begin
			cpu_err <= next_cpu_err;
			dma_err <= next_dma_err;
		end
	end

	assign cpu_rdata_out    = cpu_rdata;
	assign dma_rdata_out    = dma_rdata;
	assign cpu_addr_err_out = cpu_err;
	assign dma_addr_err_out = dma_err;
	// The CPU never waits: DMA is on its own port [RL3] [RL5]
	assign cpu_stall_out    = 1'b0;

	// Shadow of last cycle's writes, so the checks below look at the array itself
	// DMA lanes expected to land are worked out here from the rule, not taken from dma_we_eff
	logic        chk_col;
	logic        next_chk_col;
	dptr_waddr_t chk_addr;
	dptr_word_t  chk_cpu_wd;
	logic [1:0]  chk_we;
	dptr_waddr_t chk_dma_addr;
	dptr_word_t  chk_dma_wd;
	logic [1:0]  chk_dma_we;
	logic [1:0]  next_chk_dma_we;
	logic        chk_keep_on;
	logic        next_chk_keep_on;
	logic        chk_keep_hi;
	logic [7:0]  chk_keep;
	logic [7:0]  next_chk_keep;

	always_comb begin
		next_chk_col     = (cpu_we == 2'h3) && (dma_we != 2'h0) && (cpu_waddr == dma_waddr);
		next_chk_dma_we  = dma_we;
		next_chk_keep_on = (cpu_we == 2'h1) || (cpu_we == 2'h2);
		next_chk_keep    = cpu_we[0] ? mem_hi[cpu_waddr] : mem_lo[cpu_waddr];
		if (cpu_waddr == dma_waddr) begin
			next_chk_dma_we = dma_we & ~cpu_we;
			if ((dma_we & ~cpu_we) != 2'h0) begin
				next_chk_keep_on = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			chk_col      <= 1'b0;
			chk_addr     <= '0;
			chk_cpu_wd   <= 16'h0000;
			chk_we       <= 2'h0;
			chk_dma_addr <= '0;
			chk_dma_wd   <= 16'h0000;
			chk_dma_we   <= 2'h0;
			chk_keep_on  <= 1'b0;
			chk_keep_hi  <= 1'b0;
			chk_keep     <= 8'h00;
		end else begin
			chk_col      <= next_chk_col;
			chk_addr     <= cpu_waddr;
			chk_cpu_wd   <= cpu_wd;
			chk_we       <= cpu_we;
			chk_dma_addr <= dma_waddr;
			chk_dma_wd   <= dma_wd;
			chk_dma_we   <= next_chk_dma_we;
			chk_keep_on  <= next_chk_keep_on;
			chk_keep_hi  <= cpu_we[0];
			chk_keep     <= next_chk_keep;
		end
	end

	a_no_stall: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL5]
		!cpu_stall_out) else $error("CPU stall raised");
	a_cpu_wins: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL4]
		chk_col |-> ({mem_hi[chk_addr], mem_lo[chk_addr]} == chk_cpu_wd)) else $error("CPU write lost");
	a_dma_masked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL8]
		(chk_we[1] && (chk_dma_addr == chk_addr)) |-> (mem_hi[chk_addr] == chk_cpu_wd[15:8]))
		else $error("DMA write not dropped");
	a_lane_only: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		(cpu_en_in && cpu_wr_in && cpu_byte_in) |-> (cpu_we == (cpu_addr_in[0] ? 2'h2 : 2'h1)))
		else $error("Wrong CPU byte lane");
	a_dma_indep: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL2]
		(dma_en_in && dma_wr_in && dma_byte_in && !dma_addr_in[0] && (dma_waddr != cpu_waddr))
		|-> (dma_we_eff == 2'h1)) else $error("DMA write blocked");
	a_err_flag: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		(cpu_en_in && !cpu_byte_in && cpu_addr_in[0]) |=> cpu_addr_err_out) else $error("Misalign not flagged");
	a_word_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL1]
		(chk_we == 2'h3) |-> ({mem_hi[chk_addr], mem_lo[chk_addr]} == chk_cpu_wd))
		else $error("Word write not stored");
	a_no_misal_wr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		(!dma_byte_in && dma_addr_in[0]) |-> (dma_we == 2'h0)) else $error("Misaligned DMA write stored");
	a_dma_lane_lo: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL2]
		chk_dma_we[0] |-> (mem_lo[chk_dma_addr] == chk_dma_wd[7:0])) else $error("DMA low lane lost");
	a_dma_lane_hi: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL2]
		chk_dma_we[1] |-> (mem_hi[chk_dma_addr] == chk_dma_wd[15:8])) else $error("DMA high lane lost");
	a_byte_keep: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		chk_keep_on |-> ((chk_keep_hi ? mem_hi[chk_addr] : mem_lo[chk_addr]) == chk_keep))
		else $error("Byte write disturbed other lane");
	a_dma_err: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		(dma_en_in && !dma_byte_in && dma_addr_in[0]) |=> dma_addr_err_out) else $error("DMA misalign not flagged");
	a_err_pulse: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // [RL7]
		!cpu_en_in |=> !cpu_addr_err_out) else $error("CPU error flag held");

	c_collision: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) chk_col);
	c_both_wr:   cover property (@(posedge clk_sys_in) disable iff (!rstn_in) (cpu_we != 2'h0) && (dma_we != 2'h0));
	c_byte_hi:   cover property (@(posedge clk_sys_in) disable iff (!rstn_in) dma_we_eff == 2'h2);
endmodule : dptr_ram

// ===== dptr_defs.svh
// Constants for the dual-port transfer RAM
`ifndef DPTR_DEFS_SVH
`define DPTR_DEFS_SVH
`define DPTR_SIZE_BYTES  2048
`define DPTR_ADDR_W      11
`define DPTR_WADDR_W     10
`define DPTR_DEPTH       1024
`define DPTR_DATA_W      16
`define DPTR_LANE_W      8
`endif

// ===== dptr_pkg.sv
// Types for the dual-port transfer RAM
`include "dptr_defs.svh"
package dptr_pkg;
	typedef logic [`DPTR_ADDR_W-1:0]  dptr_baddr_t;
	typedef logic [`DPTR_WADDR_W-1:0] dptr_waddr_t;
	typedef logic [`DPTR_DATA_W-1:0]  dptr_word_t;
	typedef logic [1:0]               dptr_lanes_t;
endpackage : dptr_pkg

// ===== dptr_lane_dec.sv
// Byte-lane decode and write-data steering for one port
`timescale 1ns/1ps
`include "dptr_defs.svh"
module dptr_lane_dec import dptr_pkg::*; (
	input  wire logic        wr_in,
	input  wire logic        byte_in,
	input  wire dptr_baddr_t addr_in,
	input  wire dptr_word_t  wdata_in,
	output logic             aligned_out,
	output dptr_waddr_t      waddr_out,
	output dptr_lanes_t      we_out,
	output dptr_word_t       wdata_out
);
	// Byte writes land in the lane chosen by the address LSB; a misaligned word write stores nothing
	always_comb begin
		waddr_out   = addr_in[`DPTR_ADDR_W-1:1];
		aligned_out = byte_in | ~addr_in[0];
		we_out      = 2'h0;
		wdata_out   = wdata_in;
		if (wr_in && byte_in) begin
			we_out    = addr_in[0] ? 2'h2 : 2'h1; // [RL7]
			wdata_out = {wdata_in[7:0], wdata_in[7:0]};
		end else if (wr_in && !addr_in[0]) begin
			we_out = 2'h3;
		end
	end
endmodule : dptr_lane_dec

// ===== dptr_dma_model.sv
// DMA-side requester model for the transfer RAM's DMA port
`timescale 1ns/1ps
module dptr_dma_model import dptr_pkg::*; (
	output logic        en_out,
	output logic        wr_out,
	output logic        byte_out,
	output dptr_baddr_t addr_out,
	output dptr_word_t  wdata_out
);
	// Idle until the bench asks for traffic
	initial begin
		put(1'b0, 1'b0, 1'b0, '0, '0);
	end
	// Drives one DMA port request per call; an idle request inverts the held write data
	task automatic put(input logic e, w, b, input dptr_baddr_t a, input dptr_word_t d);
		en_out = e;
		wr_out = w;
		byte_out = b;
		addr_out = a;
		wdata_out = e ? d : ~wdata_out;
	endtask : put
endmodule : dptr_dma_model

// ===== dual_port_transfer_ram_tb_top.sv
// Self-checking bench for the dual-port transfer RAM
`timescale 1ns/1ps
module dual_port_transfer_ram_tb_top import dptr_pkg::*;;
	logic clk_sys_in = 0, rstn_in = 0, ce = 0, cw = 0, cb = 0, stall, cerr, den, dwr, dby, derr;
	dptr_baddr_t ca = '0, da;
	dptr_word_t  cd = '0, dd, crd, drd;
	int m[2048];
	int num_errors = 0, tests_run = 0;
	dptr_dma_model i_dptr_dma_model (.en_out(den), .wr_out(dwr), .byte_out(dby), .addr_out(da), .wdata_out(dd));
	dptr_ram i_dptr_ram (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cpu_en_in(ce), .cpu_wr_in(cw),
		.cpu_byte_in(cb), .cpu_addr_in(ca), .cpu_wdata_in(cd), .cpu_rdata_out(crd), .cpu_stall_out(stall),
		.cpu_addr_err_out(cerr), .dma_en_in(den), .dma_wr_in(dwr), .dma_byte_in(dby), .dma_addr_in(da),
		.dma_wdata_in(dd), .dma_rdata_out(drd), .dma_addr_err_out(derr));
	// 40 MHz system clock
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic stop_test;
		if (num_errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] g, input int e);
		tests_run++;
		if (g !== 16'(e)) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, 16'(e));
		end
	endtask : chk
	// Byte lanes share one word decode; byte reads come back zero-extended
	function automatic int rd(logic b, dptr_baddr_t a);
		return b ? m[a] : (m[a + 1] << 8) | m[a];
	endfunction : rd
	task automatic wr(logic b, dptr_baddr_t a, dptr_word_t d);
		m[a] = d[7:0];
		if (!b) m[a + 1] = d[15:8];
	endtask : wr
	// One cycle on both ports; DMA is applied first so a CPU lane overrides it
	task automatic cyc(logic e, w, b, dptr_baddr_t a, dptr_word_t d, logic f, v, y, dptr_baddr_t x, dptr_word_t z);
		int xc, xd;
		logic ec, ed;
		ce = e; cw = w; cb = b; ca = a; cd = d;
		i_dptr_dma_model.put(f, v, y, x, z);
		xc = rd(b, a);
		xd = rd(y, x);
		ec = e & !b & a[0];
		ed = f & !y & x[0];
		if (f & v & !ed) wr(y, x, z);
		if (e & w & !ec) wr(b, a, d);
		@(posedge clk_sys_in);
		#1;
		chk(stall, 0);
		chk(cerr, ec);
		chk(derr, ed);
		if (e & !w & !ec) chk(crd, xc);
		if (f & !v & !ed) chk(drd, xd);
	endtask : cyc
	function automatic dptr_baddr_t ad();
		return ($urandom % 4 == 0) ? 11'($urandom) : 11'($urandom % 16);
	endfunction : ad
	// Hang guard, well past the expected run length
	initial begin
		#(25 * 6000);
		num_errors++;
		stop_test();
	end
	// Fill the whole 2 Kbyte space, then collide, then random dual-port traffic
	initial begin
		void'($urandom(42));
		repeat (5) @(posedge clk_sys_in);
		#1 rstn_in = 1;
		for (int i = 0; i < 512; i++) cyc(1, 1, 0, 11'(2 * i), 16'($urandom), 1, 1, 0, 11'(2 * i + 1024), 16'($urandom));
		cyc(1, 1, 0, 11'h010, 16'h1234, 1, 1, 0, 11'h010, 16'habcd);
		cyc(1, 1, 1, 11'h011, 16'h0055, 1, 1, 0, 11'h010, 16'h9988);
		cyc(1, 0, 0, 11'h010, 16'h0000, 1, 0, 1, 11'h011, 16'h0000);
		for (int i = 0; i < 2000; i++) cyc(1'($urandom), 1'($urandom), 1'($urandom), ad(), 16'($urandom),
			1'($urandom), 1'($urandom), 1'($urandom), ad(), 16'($urandom));
		stop_test();
	end
endmodule : dual_port_transfer_ram_tb_top
